// *** src/asrp_map.vh ***
/*
 * Constants shared by the serial readout port design files.
 * Assumes inclusion by bare name from files under src/.
 */
`ifndef ASRP_MAP_VH
`define ASRP_MAP_VH

`define ASRP_RES_W       12
`define ASRP_LOCK_SCK    5'h0E
`define ASRP_FLAG_EDGE   5'h02
`define ASRP_LAST_EDGE   5'h0E
`define ASRP_NAP_COUNT   3'h2
`define ASRP_SLEEP_COUNT 3'h4
`define ASRP_SETTLE_MS   12
`define ASRP_CLK_KHZ     50000
`define ASRP_SETTLE_CYC  (`ASRP_SETTLE_MS * `ASRP_CLK_KHZ)
`define ASRP_FIFO_DEPTH  4
`define ASRP_FIFO_FULL   3'h4

`endif

// *** src/asrp_fifo.v ***
/*
 * Small flip-flop FIFO with valid and ready on both sides.
 * Assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/1ps
module asrp_fifo #(
	parameter WIDTH = 12,
	parameter DEPTH = 4,
	parameter AW    = 2
) (
	input  wire             clk,
	input  wire             rst_n,
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	output wire             out_valid,
	input  wire             out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr;
	reg [AW-1:0]    rd_ptr;
	reg [AW:0]      count;
	wire            do_wr;
	wire            do_rd;

	assign in_ready  = (count != DEPTH[AW:0]);
	assign out_valid = (count != {(AW+1){1'b0}});
	assign out_data  = mem[rd_ptr];
	assign do_wr     = in_valid & in_ready;
	assign do_rd     = out_valid & out_ready;

	// ==========================================
	// Pointers and occupancy.
	always @(posedge clk) begin
		if (!rst_n) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count  <= {(AW+1){1'b0}};
		end else begin
			if (do_wr) begin
				mem[wr_ptr] <= in_data;
				wr_ptr      <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
			end
			if (do_rd)
				rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
			if (do_wr & ~do_rd)
				count <= count + 1'b1;
			else if (do_rd & ~do_wr)
				count <= count - 1'b1;
		end
	end
endmodule

// *** src/asrp_port.v ***
/*
 * Conversion control and serial readout port of a 12-bit sampling converter.
 * Assumes convert_strobe and serial clock arrive asynchronously from the host,
 * and that converter results arrive as valid words on the clk domain.
 */
`timescale 1ns/1ps
`include "asrp_map.vh"

// Summary of operation
// - Start rising edge begins conversion unless in sleep; further edges ignored for 14 serial clocks.
// - Start strobe of any duty cycle is accepted; only its rising edge counts.
// - Each serial clock rising edge steps conversion; from the second edge on, each also updates the output bit.
// - Reference settled flag appears on the second serial clock edge after start.
// - Then twelve result bits follow, most significant bit first.
// - Each bit holds steady until the next serial clock rising edge.
// - Output is undriven after reset until the first conversion starts.
// - Thirteen bits per conversion, starting at the second serial clock edge.
// - Two start edges without clock edge enter nap; a clock edge wakes.
// - Four start edges without clock edge enter sleep; a clock edge wakes.
// - After sleep wake, settled flag stays low about twelve milliseconds.
// - Range pin high gives two's complement; low gives straight binary.
module asrp_port #(
	parameter RES_W      = `ASRP_RES_W,
	parameter SETTLE_CYC = `ASRP_SETTLE_CYC
) (
	input  wire             clk,
	input  wire             rst_n,
	input  wire             convert_strobe,
	input  wire             serial_clock,
	input  wire             range_select,
	input  wire [RES_W-1:0] sample_data,
	input  wire             sample_valid,
	output reg              sample_ready,
	output reg              data_out,
	output reg              data_out_oe_n,
	output reg              nap_mode,
	output reg              sleep_mode,
	output reg              reference_settled_flag
);
	localparam ST_IDLE  = 1'b0;
	localparam ST_CONVERT_STROBE  = 1'b1;

	reg             convert_strobe_s1;
	reg             convert_strobe_s2;
	reg             convert_strobe_d;
	reg             sck_s1;
	reg             sck_s2;
	reg             sck_d;
	reg             range_s1;
	reg             range_s2;
	reg             state;
	reg  [4:0]      sck_cnt;
	reg  [RES_W:0]  shift;
	reg  [2:0]      idle_starts;
	reg  [31:0]     settle_cnt;
	reg             started;
	wire            convert_strobe_rise;
	wire            sck_rise;
	wire            fifo_valid;
	wire [RES_W-1:0] fifo_data;
	wire            take_word;
	wire [RES_W-1:0] coded;
	reg  [2:0]      fifo_level;
	reg  [2:0]      next_fifo_level;
	wire            push;
	wire            pop;

	// ==========================================
	// Input synchronisers and edge detection.
	always @(posedge clk) begin
		if (!rst_n) begin
			convert_strobe_s1  <= 1'b0;
			convert_strobe_s2  <= 1'b0;
			convert_strobe_d   <= 1'b0;
			sck_s1   <= 1'b0;
			sck_s2   <= 1'b0;
			sck_d    <= 1'b0;
			range_s1 <= 1'b0;
			range_s2 <= 1'b0;
		end else begin
			convert_strobe_s1  <= convert_strobe;
			convert_strobe_s2  <= convert_strobe_s1;
			convert_strobe_d   <= convert_strobe_s2;
			sck_s1   <= serial_clock;
			sck_s2   <= sck_s1;
			sck_d    <= sck_s2;
			range_s1 <= range_select;
			range_s2 <= range_s1;
		end
	end

	assign convert_strobe_rise = convert_strobe_s2 & ~convert_strobe_d;
	assign sck_rise  = sck_s2 & ~sck_d;

	// ==========================================
	// Result buffer between converter core and shifter.
	asrp_fifo #(
		.WIDTH (RES_W),
		.DEPTH (`ASRP_FIFO_DEPTH),
		.AW    (2)
	) u_fifo (
		.clk       (clk),
		.rst_n     (rst_n),
		.in_valid  (push),
		.in_ready  (),
		.in_data   (sample_data),
		.out_valid (fifo_valid),
		.out_ready (take_word),
		.out_data  (fifo_data)
	);

	assign take_word = (state == ST_CONVERT_STROBE) & sck_rise & (sck_cnt == `ASRP_FLAG_EDGE - 5'h01);
	assign coded     = range_s2 ? {~fifo_data[RES_W-1], fifo_data[RES_W-2:0]}
	                            : fifo_data;

	// ==========================================
	// Registered ready, kept from a mirror of the buffer occupancy.
	assign push = sample_valid & sample_ready;
	assign pop  = take_word & fifo_valid;

	always @* begin
		next_fifo_level = fifo_level;
		if (push && !pop)
			next_fifo_level = fifo_level + 3'h1;
		else if (pop && !push)
			next_fifo_level = fifo_level - 3'h1;
	end

	always @(posedge clk) begin
		if (!rst_n) begin
			fifo_level   <= 3'h0;
			sample_ready <= 1'b0;
		end else begin
			fifo_level   <= next_fifo_level;
			sample_ready <= (next_fifo_level != `ASRP_FIFO_FULL);
		end
	end

	// ==========================================
	// Conversion sequencer and serial shifter.
	always @(posedge clk) begin
		if (!rst_n) begin
			state         <= ST_IDLE;
			sck_cnt       <= 5'h00;
			shift         <= {(RES_W+1){1'b0}};
			data_out      <= 1'b0;
			data_out_oe_n <= 1'b1;
			started       <= 1'b0;
		end else begin
			case (state)
			ST_IDLE: begin
				if (convert_strobe_rise && !sleep_mode) begin
					state   <= ST_CONVERT_STROBE;
					sck_cnt <= 5'h00;
					started <= 1'b1;
					data_out_oe_n <= 1'b0;
				end
			end
			ST_CONVERT_STROBE: begin
				if (sck_rise) begin
					sck_cnt <= sck_cnt + 5'h01;
					if (sck_cnt == `ASRP_FLAG_EDGE - 5'h01) begin
						shift    <= {reference_settled_flag,
						             fifo_valid ? coded : {RES_W{1'b0}}};
						data_out <= reference_settled_flag;
					end else if (sck_cnt >= `ASRP_FLAG_EDGE &&
					             sck_cnt < `ASRP_LAST_EDGE) begin
						data_out <= shift[RES_W-1];
						shift    <= {shift[RES_W-1:0], 1'b0};
					end
					if (sck_cnt == `ASRP_LOCK_SCK - 5'h01)
						state <= ST_IDLE;
				end
			end
			default: state <= ST_IDLE;
			endcase
		end
	end

	// ==========================================
	// Nap and sleep entry by repeated start edges.
	always @(posedge clk) begin
		if (!rst_n) begin
			idle_starts <= 3'h0;
			nap_mode    <= 1'b0;
			sleep_mode  <= 1'b0;
		end else if (sck_rise) begin
			idle_starts <= 3'h0;
			nap_mode    <= 1'b0;
			sleep_mode  <= 1'b0;
		end else if (convert_strobe_rise) begin
			// Start edges count, busy or not, up to four; a clock edge clears the tally and wins over a start edge in the same cycle.
			if (idle_starts != `ASRP_SLEEP_COUNT)
				idle_starts <= idle_starts + 3'h1;
			if (idle_starts + 3'h1 >= `ASRP_NAP_COUNT)
				nap_mode <= 1'b1;
			if (idle_starts + 3'h1 >= `ASRP_SLEEP_COUNT)
				sleep_mode <= 1'b1;
		end
	end

	// ==========================================
	// Reference settling after sleep.
	always @(posedge clk) begin
		if (!rst_n) begin
			settle_cnt             <= 32'h0;
			reference_settled_flag <= 1'b1;
		end else if (sleep_mode) begin
			settle_cnt             <= SETTLE_CYC[31:0];
			reference_settled_flag <= 1'b0;
		end else if (settle_cnt != 32'h0) begin
			settle_cnt             <= settle_cnt - 32'h1;
			reference_settled_flag <= (settle_cnt == 32'h1);
		end
	end
endmodule

// *** testbench/asrp_port_asserts.sv ***
/* Pin-level checks of the readout port.
   Sees only the top ports; bound to asrp_port below. */
`timescale 1ns/1ps
module asrp_port_asserts #(parameter RES_W = 12, parameter SETTLE_CYC = 50) (
	input wire logic             clk, rst_n, convert_strobe, serial_clock, range_select,
	input wire logic [RES_W-1:0] sample_data,
	input wire logic             sample_valid, sample_ready, data_out, data_out_oe_n,
	input wire logic             nap_mode, sleep_mode, reference_settled_flag
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_reset_idle: assert property ($rose(rst_n) |-> data_out_oe_n && !nap_mode && !sleep_mode && reference_settled_flag)
		else $error("outputs not idle after reset");
	a_oe_cause: assert property ($fell(data_out_oe_n) |-> $past(convert_strobe, 3))
		else $error("output enabled without start");
	a_oe_held: assert property (!data_out_oe_n |=> !data_out_oe_n)
		else $error("output released");
	a_bit_moment: assert property ($changed(data_out) |-> $past(serial_clock, 3) && !$past(serial_clock, 6))
		else $error("data changed off clock edge");
	a_nap_wake: assert property (nap_mode && $rose(serial_clock) |-> ##[1:6] !nap_mode)
		else $error("nap not left");
	a_sleep_wake: assert property (sleep_mode && $rose(serial_clock) |-> ##[1:6] !sleep_mode)
		else $error("sleep not left");
	a_settle_low: assert property ($fell(sleep_mode) |-> ##2 !reference_settled_flag [*8])
		else $error("settled flag high too soon");
	a_ready_cause: assert property ($fell(sample_ready) |-> $past(sample_valid))
		else $error("ready fell without push");
	c_start: cover property ($fell(data_out_oe_n));
	c_nap: cover property ($rose(nap_mode));
	c_sleep: cover property ($rose(sleep_mode));
endmodule
bind asrp_port asrp_port_asserts #(.RES_W(RES_W), .SETTLE_CYC(SETTLE_CYC)) asrp_port_asserts_inst (
	.clk(clk), .rst_n(rst_n), .convert_strobe(convert_strobe), .serial_clock(serial_clock),
	.range_select(range_select), .sample_data(sample_data), .sample_valid(sample_valid),
	.sample_ready(sample_ready), .data_out(data_out), .data_out_oe_n(data_out_oe_n),
	.nap_mode(nap_mode), .sleep_mode(sleep_mode), .reference_settled_flag(reference_settled_flag));

// *** testbench/asrp_host.sv ***
/* Host serial receiver: makes the serial clock and shifts in the bits.
   Assumes run rises once per burst of n_sck clocks. */
`timescale 1ns/1ps
module asrp_host (
	input wire logic        run, data_out, data_out_oe_n,
	input wire logic [4:0]  n_sck,
	output logic            serial_clock,
	output logic            busy,
	output logic [12:0]     word
);
	wire line = data_out_oe_n ? 1'bz : data_out;
	initial begin
		serial_clock = 1'b0;
		busy = 1'b0;
		word = 13'h0000;
	end
	always @(posedge run) begin
		busy = 1'b1;
		#7;
		for (int i = 1; i <= n_sck; i++) begin
			#80 serial_clock = 1'b1;
			if (i >= 3 && i <= 15) word = {word[11:0], line};
			#80 serial_clock = 1'b0;
		end
		busy = 1'b0;
	end
endmodule

// *** testbench/asrp_port_tb.sv ***
/* Self-checking bench of the readout port with a host model.
   Assumes the design files under src/. */
`timescale 1ns/1ps
module asrp_port_tb;
	logic        clk, rst_n, convert_strobe, range_select, sample_valid, run;
	logic [11:0] sample_data;
	logic [4:0]  n_sck;
	wire         serial_clock, sample_ready, data_out, data_out_oe_n, nap, sleep, flag, busy;
	wire [12:0]  word;
	int          n_errors, tests_run, i, k;
	logic [11:0] w [4] = '{12'h800, 12'h7FF, 12'hA5C, 12'h001};
	asrp_port #(.SETTLE_CYC(50)) asrp_port_inst (.clk(clk), .rst_n(rst_n),
		.convert_strobe(convert_strobe), .serial_clock(serial_clock), .range_select(range_select),
		.sample_data(sample_data), .sample_valid(sample_valid), .sample_ready(sample_ready),
		.data_out(data_out), .data_out_oe_n(data_out_oe_n), .nap_mode(nap), .sleep_mode(sleep),
		.reference_settled_flag(flag));
	asrp_host asrp_host_inst (.run(run), .data_out(data_out), .data_out_oe_n(data_out_oe_n),
		.n_sck(n_sck), .serial_clock(serial_clock), .busy(busy), .word(word));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic check(string name, logic [12:0] exp, logic [12:0] got);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic wait_idle();
		k = 0;
		@(posedge clk);
		while (busy && k < 400) begin
			@(posedge clk);
			k++;
		end
		if (busy) begin
			n_errors++;
			end_of_test();
		end
	endtask
	task automatic frame(logic [12:0] exp, logic extra);
		convert_strobe <= 1'b1; run <= 1'b1; n_sck <= 5'h10;
		repeat (8) @(posedge clk);
		convert_strobe <= 1'b0; run <= 1'b0;
		repeat (24) @(posedge clk);
		convert_strobe <= extra;
		repeat (8) @(posedge clk);
		convert_strobe <= 1'b0;
		wait_idle();
		check("frame word", exp, word);
	endtask
	task automatic pulses(int n);
		repeat (n) begin
			convert_strobe <= 1'b1; repeat (4) @(posedge clk);
			convert_strobe <= 1'b0; repeat (4) @(posedge clk);
		end
		repeat (4) @(posedge clk);
		#1;
	endtask
	task automatic wake();
		@(posedge clk);
		n_sck <= 5'h01; run <= 1'b1; @(posedge clk);
		run <= 1'b0; wait_idle(); repeat (6) @(posedge clk);
		#1;
	endtask
	initial begin
		n_errors = 0; tests_run = 0; rst_n = 1'b0; convert_strobe = 1'b0; range_select = 1'b0;
		sample_valid = 1'b0; sample_data = 12'h000; run = 1'b0; n_sck = 5'h10;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1; @(posedge clk); #1;
		check("oe idle", 13'h1, {12'h0, data_out_oe_n});
		@(posedge clk);
		for (i = 0; i < 4; i++) begin
			sample_data <= w[i]; sample_valid <= 1'b1; @(posedge clk);
		end
		sample_valid <= 1'b0; #1;
		check("ready full", 13'h0, {12'h0, sample_ready});
		$display("fill test done");
		@(posedge clk);
		for (i = 0; i < 5; i++) begin
			range_select <= i[0];
			frame(i < 4 ? {1'b1, w[i[1:0]] ^ {i[0], 11'h0}} : 13'h1000, i == 1);
		end
		check("oe driven", 13'h0, {12'h0, data_out_oe_n});
		$display("frame test done");
		pulses(2);
		check("nap", 13'h1, {12'h0, nap});
		wake();
		check("nap left", 13'h0, {12'h0, nap});
		@(posedge clk);
		pulses(4);
		check("sleep", 13'h1, {12'h0, sleep});
		wake();
		check("sleep left", 13'h0, {12'h0, sleep});
		check("flag low", 13'h0, {12'h0, flag});
		k = 0;
		while (!flag && k < 100) begin
			@(posedge clk);
			k++;
		end
		#1;
		check("flag back", 13'h1, {12'h0, flag});
		$display("power test done");
		end_of_test();
	end
endmodule
